// file: hdl/pmif_pkg.sv
// register map, field positions, reset values and carrier types for the
// interrupt flag and mask block.
// assumes a byte-wide subaddress port fed by the serial control bus decoder.
package pmif_pkg;

    // ========================================================
    // register offsets
    localparam logic [7:0] PMIF_OFS_EVENT_FLAGS_A = 8'h01;
    localparam logic [7:0] PMIF_OFS_SWITCH_FLAGS = 8'h02;
    localparam logic [7:0] PMIF_OFS_EVENT_MASK_A = 8'h03;

    // ========================================================
    // reset values and widths
    localparam int PMIF_FLAG_W = 6;
    localparam logic [7:0] PMIF_RST_EVENT_FLAGS_A = 8'h00;
    localparam logic [7:0] PMIF_RST_SWITCH_FLAGS = 8'h00;
    localparam logic [7:0] PMIF_RST_EVENT_MASK_A = 8'h00;
    localparam logic [7:0] PMIF_UNMAPPED_READ = 8'h00;
    localparam logic [1:0] PMIF_RESERVED_TOP = 2'h0;

    // ========================================================
    // event_flags_a / event_mask_a bit positions
    localparam int PMIF_BIT_PROG_SUPPLY_LOW = 5;
    localparam int PMIF_BIT_MAINS_CHANGE = 4;
    localparam int PMIF_BIT_BUTTON_CHANGE = 3;
    localparam int PMIF_BIT_OVERTEMP = 2;
    localparam int PMIF_BIT_CELL_DONE = 1;
    localparam int PMIF_BIT_NVM_DONE = 0;

    // ========================================================
    // switch_event_flags bit positions
    localparam int PMIF_BIT_SW3_FAULT = 5;
    localparam int PMIF_BIT_SW2_FAULT = 4;
    localparam int PMIF_BIT_SW1_FAULT = 3;
    localparam int PMIF_BIT_SW3_LIMIT = 2;
    localparam int PMIF_BIT_SW2_LIMIT = 1;
    localparam int PMIF_BIT_SW1_LIMIT = 0;

    // ========================================================
    // carriers
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pmif_reg_req_t;

    typedef struct packed {
        logic [2:0] overtemp;
        logic sw2_input_low;
        logic [2:0] limiting;
        logic [2:0] enabled;
    } pmif_switch_in_t;

    typedef struct packed {
        logic prog_supply_low;
        logic overtemp_warning;
        logic cell_settled;
        logic nvm_program_done;
    } pmif_event_in_t;

endpackage

// file: hdl/pmif_flag_bank.sv
// a bank of sticky flags: set by hardware, cleared by a read strobe.
// assumes set and clear arrive as single-clock requests on i_mclk.
module pmif_flag_bank #(
    parameter int W = 6
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_set,
    input wire logic [W-1:0] i_clr,
    output logic [W-1:0] o_flags
);

    // ========================================================
    // storage
    logic [W-1:0] flags_reg;

    // set wins over a clear landing in the same cycle, so no event is lost
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= (flags_reg & ~i_clr) | i_set;
        end
    end

    assign o_flags = flags_reg;

endmodule

// file: hdl/pmif_irq_flags.sv
// interrupt flags and first mask register of the power-management block.
// assumes an upstream serial bus decoder presents subaddress reads/writes
// as one-cycle strobes; all inputs are synchronous to i_mclk.
module pmif_irq_flags (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire pmif_pkg::pmif_reg_req_t i_reg_req,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_ack,
    input wire logic i_mains_present_in_n,
    input wire logic i_button_in_n,
    input wire pmif_pkg::pmif_event_in_t i_event,
    input wire pmif_pkg::pmif_switch_in_t i_switch,
    output logic o_mains_state,
    output logic o_button_state,
    output logic [2:0] o_switch_hold,
    output logic o_irq_out_n
);
    import pmif_pkg::*;

    // ========================================================
    // helpers
    function automatic logic [7:0] pad_reg(input logic [5:0] v);
        pad_reg = {PMIF_RESERVED_TOP, v};
    endfunction

    function automatic logic is_read_of(input pmif_reg_req_t r,
                                        input logic [7:0] ofs);
        is_read_of = r.rd && (r.addr == ofs);
    endfunction

    // ========================================================
    // declarations
    logic mains_prev_reg;
    logic button_prev_reg;
    logic pins_primed_reg;
    logic [PMIF_FLAG_W-1:0] mask_a_reg;
    logic [PMIF_FLAG_W-1:0] set_a;
    logic [PMIF_FLAG_W-1:0] clr_a;
    logic [PMIF_FLAG_W-1:0] flags_a;
    logic [2:0] set_fault;
    logic [2:0] clr_fault;
    logic [2:0] fault_flags;
    logic [2:0] limit_live;
    logic [2:0] hold_reg;
    logic [7:0] rdata_reg;
    logic ack_reg;
    logic irq_n_reg;
    logic [7:0] switch_word;

    // ========================================================
    // pin change detection
    // the first sample after reset only primes the history, so release of
    // reset never raises a false change event
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            mains_prev_reg <= 1'b1;
            button_prev_reg <= 1'b1;
            pins_primed_reg <= 1'b0;
        end else begin
            mains_prev_reg <= i_mains_present_in_n;
            button_prev_reg <= i_button_in_n;
            pins_primed_reg <= 1'b1;
        end
    end

    assign o_mains_state = ~mains_prev_reg;
    assign o_button_state = ~button_prev_reg;

    // ========================================================
    // event_flags_a set terms
    always_comb begin
        set_a = '0;
        set_a[PMIF_BIT_PROG_SUPPLY_LOW] = i_event.prog_supply_low;
        set_a[PMIF_BIT_MAINS_CHANGE] = pins_primed_reg &&
            (i_mains_present_in_n != mains_prev_reg);
        set_a[PMIF_BIT_BUTTON_CHANGE] = pins_primed_reg &&
            (i_button_in_n != button_prev_reg);
        set_a[PMIF_BIT_OVERTEMP] = i_event.overtemp_warning;
        set_a[PMIF_BIT_CELL_DONE] = i_event.cell_settled;
        set_a[PMIF_BIT_NVM_DONE] = i_event.nvm_program_done;
    end

    // clear on read of the register
    assign clr_a = is_read_of(i_reg_req, PMIF_OFS_EVENT_FLAGS_A) ?
        '1 : '0;

    pmif_flag_bank #(
        .W(PMIF_FLAG_W)
    ) u_flags_a (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_set(set_a),
        .i_clr(clr_a),
        .o_flags(flags_a)
    );

    // ========================================================
    // switch faults: index 0..2 is switch 1..3
    // overheat sets switch 3..1 faults
    // switch 2 also faults on low input
    assign set_fault = {i_switch.overtemp[2],
                        i_switch.overtemp[1] | i_switch.sw2_input_low,
                        i_switch.overtemp[0]};
    assign clr_fault = is_read_of(i_reg_req, PMIF_OFS_SWITCH_FLAGS) ?
        3'h7 : 3'h0;

    pmif_flag_bank #(
        .W(3)
    ) u_fault_flags (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_set(set_fault),
        .i_clr(clr_fault),
        .o_flags(fault_flags)
    );

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            hold_reg <= 3'h0;
        end else begin
            hold_reg <= set_fault;
        end
    end

    assign o_switch_hold = hold_reg;

    // zero when disabled, held off or idle
    assign limit_live = i_switch.limiting & i_switch.enabled & ~hold_reg;

    always_comb begin
        switch_word = PMIF_RST_SWITCH_FLAGS;
        switch_word[PMIF_BIT_SW3_FAULT] = fault_flags[2];
        switch_word[PMIF_BIT_SW2_FAULT] = fault_flags[1];
        switch_word[PMIF_BIT_SW1_FAULT] = fault_flags[0];
        switch_word[PMIF_BIT_SW3_LIMIT] = limit_live[2];
        switch_word[PMIF_BIT_SW2_LIMIT] = limit_live[1];
        switch_word[PMIF_BIT_SW1_LIMIT] = limit_live[0];
    end

    // ========================================================
    // event_mask_a
    // read-write mask, reset zero
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            mask_a_reg <= PMIF_RST_EVENT_MASK_A[PMIF_FLAG_W-1:0];
        end else if (i_reg_req.wr &&
                     i_reg_req.addr == PMIF_OFS_EVENT_MASK_A) begin
            mask_a_reg <= i_reg_req.wdata[PMIF_FLAG_W-1:0];
        end
    end

    // ========================================================
    // read port: data captured before the clear-on-read takes effect
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            rdata_reg <= PMIF_UNMAPPED_READ;
        end else if (i_reg_req.rd) begin
            unique case (i_reg_req.addr)
                PMIF_OFS_EVENT_FLAGS_A: rdata_reg <= pad_reg(flags_a);
                PMIF_OFS_SWITCH_FLAGS: rdata_reg <= switch_word;
                PMIF_OFS_EVENT_MASK_A: rdata_reg <= pad_reg(mask_a_reg);
                default: rdata_reg <= PMIF_UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= i_reg_req.rd | i_reg_req.wr;
        end
    end

    assign o_reg_rdata = rdata_reg;
    assign o_reg_ack = ack_reg;

    // ========================================================
    // interrupt pin
    // second mask register is absent, so switch faults are never masked;
    // live limit bits are left off the pin to avoid chatter during limiting
    // unmasked flag pulls pin low
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            irq_n_reg <= 1'b1;
        end else begin
            irq_n_reg <= ~(|(flags_a & ~mask_a_reg) | (|fault_flags));
        end
    end

    assign o_irq_out_n = irq_n_reg;

endmodule

// file: tb/pmif_irq_chk_assertions.sv
// checker for the flag block, bound to its top module ports.
// assumes one clock domain and an async active-high reset.
module pmif_irq_chk
    import pmif_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire pmif_pkg::pmif_reg_req_t i_reg_req,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_ack,
    input wire logic i_mains_present_in_n,
    input wire pmif_pkg::pmif_event_in_t i_event,
    input wire pmif_pkg::pmif_switch_in_t i_switch,
    input wire logic o_mains_state,
    input wire logic [2:0] o_switch_hold,
    input wire logic o_irq_out_n
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    logic rq;
    logic rd_a;
    logic [2:0] flt;
    logic [2:0] lim;
    assign rq = i_reg_req.rd | i_reg_req.wr;
    assign rd_a = i_reg_req.rd && i_reg_req.addr == 8'h01;
    assign flt = i_switch.overtemp | {1'b0, i_switch.sw2_input_low, 1'b0};
    assign lim = i_switch.limiting & i_switch.enabled & ~o_switch_hold;
    // ========
    // properties
    AST_ACK: assert property (rq |=> o_reg_ack)
        else $error("strobe not acknowledged");
    AST_RESV: assert property (o_reg_ack |-> o_reg_rdata[7:6] == 2'h0)
        else $error("reserved bits not zero");
    AST_UNMAP: assert property (i_reg_req.rd && (i_reg_req.addr == 8'h00 ||
        i_reg_req.addr > 8'h03) |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    // nvm flag must survive until the next read of its bank
    AST_NVM: assert property (i_event.nvm_program_done ##1 (!i_reg_req.rd)[*3]
        ##1 rd_a |=> o_reg_rdata[0])
        else $error("nvm done flag lost");
    AST_FAULT_IRQ: assert property (|flt |-> ##2 !o_irq_out_n)
        else $error("switch fault did not raise interrupt");
    AST_HOLD: assert property (1 |=> o_switch_hold == $past(flt))
        else $error("switch hold does not follow fault");
    AST_MAINS: assert property (1 |=> o_mains_state ==
        !$past(i_mains_present_in_n))
        else $error("mains state polarity wrong");
    AST_LIMIT: assert property (i_reg_req.rd && i_reg_req.addr == 8'h02
        |=> o_reg_rdata[2:0] == $past(lim))
        else $error("limit bits wrong");
    cover property (!o_irq_out_n);
    cover property (i_reg_req.wr && i_reg_req.addr == 8'h03);
    cover property (|o_switch_hold);
endmodule

// file: tb/pmif_host.sv
// host model: one-byte register accesses over the strobe port.
// assumes the block acknowledges one cycle after each strobe.
module pmif_host
    import pmif_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_ack,
    input wire logic [7:0] i_rdata,
    output pmif_pkg::pmif_reg_req_t o_req
);
    timeunit 1ns;
    timeprecision 1ns;
    initial o_req = '0;
    // ========
    // host access
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [7:0] d, output logic k, output logic [7:0] q);
        @(posedge i_mclk);
        #1 o_req = '{rd: !w, wr: w, addr: a, wdata: d};
        @(posedge i_mclk);
        // idle bus shows inverted values so stale data never matches
        #1 o_req = '{1'b0, 1'b0, ~a, ~d};
        k = i_ack;
        q = i_rdata;
    endtask
endmodule

// file: tb/tb.sv
// testbench: host model, pin and event drivers around the flag block.
// assumes the checker module is compiled alongside.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pmif_pkg::*;
    logic clk, rst, ack, irq_n, ms, bs, mains_n, btn_n;
    logic [7:0] rdata, q;
    logic [2:0] hold;
    pmif_reg_req_t req;
    pmif_event_in_t ev;
    pmif_switch_in_t sw;
    int fail_count, checks_done, cyc;
    pmif_host host (.i_mclk(clk), .i_ack(ack), .i_rdata(rdata), .o_req(req));
    pmif_irq_flags uut (.i_mclk(clk), .i_rst(rst), .i_reg_req(req),
        .o_reg_rdata(rdata), .o_reg_ack(ack), .i_mains_present_in_n(mains_n),
        .i_button_in_n(btn_n), .i_event(ev), .i_switch(sw),
        .o_mains_state(ms), .o_button_state(bs), .o_switch_hold(hold),
        .o_irq_out_n(irq_n));
    // ========
    // tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic k;
        host.xfer(1'b0, a, 8'h00, k, q);
        chk({7'h00, k}, 8'h01);
        chk(q, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic k;
        host.xfer(1'b1, a, d, k, q);
        chk({7'h00, k}, 8'h01);
    endtask
    // pins toggle and stay, so two passes give both edges
    task automatic fire(input int i);
        @(posedge clk);
        #1;
        case (i)
            5: ev.prog_supply_low = 1'b1;
            4: mains_n = !mains_n;
            3: btn_n = !btn_n;
            2: ev.overtemp_warning = 1'b1;
            1: ev.cell_settled = 1'b1;
            default: ev.nvm_program_done = 1'b1;
        endcase
        @(posedge clk);
        #1 ev = '0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ========
    // clock, timeout, sequence
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc > 2000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        rst = 1'b1;
        ev = '0;
        sw = '0;
        mains_n = 1'b1;
        btn_n = 1'b1;
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        for (int a = 1; a < 5; a++)
            rd(8'(a), 8'h00);
        chk({7'h00, irq_n}, 8'h01);
        wr(8'h01, 8'hff);
        wr(8'h03, 8'hff);
        rd(8'h01, 8'h00);
        rd(8'h03, 8'h3f);
        for (int m = 0; m < 2; m++) begin
            wr(8'h03, m ? 8'h3f : 8'h00);
            for (int i = 0; i < 6; i++) begin
                fire(i);
                chk({7'h00, irq_n}, {7'h00, m[0]});
                chk({6'h00, ms, bs}, {6'h00, !mains_n, !btn_n});
                rd(8'h01, 8'h01 << i);
                rd(8'h01, 8'h00);
                chk({7'h00, irq_n}, 8'h01);
            end
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            #1;
            if (i < 3)
                sw.overtemp[i] = 1'b1;
            else
                sw.sw2_input_low = 1'b1;
            @(posedge clk);
            #1 sw = '0;
            chk({5'h00, hold}, {5'h00, (i < 3) ? 3'h1 << i : 3'h2});
            repeat (2) @(posedge clk);
            #1 chk({7'h00, irq_n}, 8'h00);
            rd(8'h02, 8'h08 << ((i == 3) ? 1 : i));
            rd(8'h02, 8'h00);
        end
        sw.enabled = 3'h7;
        sw.limiting = 3'h5;
        rd(8'h02, 8'h05);
        sw.enabled = 3'h4;
        sw.overtemp = 3'h4;
        rd(8'h02, 8'h20);
        stop_test();
    end
endmodule
bind pmif_irq_flags pmif_irq_chk u_chk (.*);
